// ---- pmftg_map.svh ----
`ifndef PMFTG_MAP_SVH
`define PMFTG_MAP_SVH
// ****************************************
// register indices (byte address = 4 x index)
// ****************************************
`define PMFTG_IDX_PIN_CTL   8'h17
`define PMFTG_IDX_TRIG_CTL  8'h18
`define PMFTG_IDX_HIGH_1    8'h19
`define PMFTG_IDX_HIGH_0    8'h1A
`define PMFTG_IDX_LOW_1     8'h1B
`define PMFTG_IDX_LOW_0     8'h1C
`define PMFTG_IDX_PORT_MASK 8'h30
`define PMFTG_IDX_STATUS    8'h31
// ****************************************
// pin control fields
// ****************************************
`define PMFTG_PIN_SEL       7:5
`define PMFTG_PIN_SRC       4:2
`define PMFTG_PIN_VAL       1
`define PMFTG_PIN_EN        0
// ****************************************
// trigger control fields
// ****************************************
`define PMFTG_TRG_MODE      7:4
`define PMFTG_TRG_SINGLE    3
`define PMFTG_TRG_INIT      2
`define PMFTG_TRG_DUTY      1
`define PMFTG_TRG_ENABLE    0
// ****************************************
// reset values and constants
// ****************************************
`define PMFTG_RST_BYTE      8'h00
`define PMFTG_RST_MASK      4'hF
`define PMFTG_SRC_STATUS    3'h4
`define PMFTG_SRC_RSVD      3'h5
`define PMFTG_LEN_ZERO      24'h000000
`define PMFTG_LEN_ONE       24'h000001
`endif

// ---- pmftg_pkg.sv ----
package pmftg_pkg;
  // forwarded inputs and status of one receive port
  typedef struct packed {
    logic [3:0] fwd;   // forwarded inputs 3..0
    logic       lock;  // port locked
    logic       pass;  // port pass
    logic       fv;    // frame valid
    logic       lv;    // line valid
  } pmftg_rx_s;
  // status of one transmit port
  typedef struct packed {
    logic fv;          // sending frame
    logic lv;          // sending line
    logic synced;      // multi-port synchronized
    logic irq;         // port interrupt
  } pmftg_tx_s;
  // trigger generator states
  typedef enum logic [1:0] {
    PMFTG_IDLE,
    PMFTG_RUN,
    PMFTG_SINGLE
  } pmftg_state_e;
endpackage

// ---- pmftg_trig_gen.sv ----
`timescale 1ns/1ps
`include "pmftg_map.svh"
module pmftg_trig_gen
  import pmftg_pkg::*;
#(
  parameter int LEN_W = 24  // width of a phase length
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             pclk_en,
  input  wire logic             tick,
  input  wire logic             cont_en,
  input  wire logic             single_go,
  input  wire logic             init_level,
  input  wire logic [LEN_W-1:0] high_len,
  input  wire logic [LEN_W-1:0] low_len,
  output logic                  trig_out,
  output logic                  busy
);
  // ****************************************
  // state
  // ****************************************
  pmftg_state_e     state_q,  state_d;  // run state
  logic [LEN_W-1:0] cnt_q,    cnt_d;    // ticks left in phase, minus one
  logic             level_q,  level_d;  // present trigger level

  // phase length of a level, as programmed (count minus one)
  function automatic logic [LEN_W-1:0] len_of(input logic lvl);
    len_of = lvl ? high_len : low_len;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    level_d = level_q;
    unique case (state_q)
      PMFTG_IDLE:
      begin
        level_d = init_level;  // rest at the initial level
        if (cont_en)
        begin
          // run starts from the initial level
          state_d = PMFTG_RUN;
          cnt_d   = len_of(init_level);
        end
        else if (single_go)
        begin
          // one pulse of the opposite level
          state_d = PMFTG_SINGLE;
          level_d = ~init_level;
          cnt_d   = len_of(~init_level);
        end
      end
      PMFTG_RUN:
      begin
        if (!cont_en)
        begin
          state_d = PMFTG_IDLE;  // stop at once
          level_d = init_level;
        end
        else if (tick)
        begin
          if (cnt_q == `PMFTG_LEN_ZERO)
          begin
            // value 0 gives a one-tick phase
            level_d = ~level_q;
            cnt_d   = len_of(~level_q);
          end
          else
          begin
            cnt_d = cnt_q - `PMFTG_LEN_ONE;
          end
        end
      end
      PMFTG_SINGLE:
      begin
        if (tick)
        begin
          if (cnt_q == `PMFTG_LEN_ZERO)
          begin
            state_d = PMFTG_IDLE;  // exactly one pulse
            level_d = init_level;
          end
          else
          begin
            cnt_d = cnt_q - `PMFTG_LEN_ONE;
          end
        end
      end
      default:
      begin
        state_d = PMFTG_IDLE;
        level_d = init_level;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= PMFTG_IDLE;
      cnt_q   <= '0;
      level_q <= 1'b0;
    end
    else if (pclk_en)
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      level_q <= level_d;
    end
  end

  assign trig_out = level_q;
  assign busy     = (state_q != PMFTG_IDLE);
endmodule

// ---- pmftg_top.sv ----
// Notes on behaviour
// - source field picks rx, status or tx
// - rx source: forwarded inputs, lock, pass, valids
// - status source: value, lock or/and, pass, trigger
// - tx source: pass and/or, valids, sync, interrupt
// - value bit drives pin in local mode
// - enable bit gates pin driver, resets low
// - modes 0-3 time from back-channel frame clock
// - modes 01xx time from reference clock
// - modes 1xxx take trigger from external pin
// - single request fires one pulse, reads zero
// - initial level bit sets trigger start level
// - high/low mode uses two 16-bit periods
// - 50/50 mode uses one 24-bit period
// - continuous enable starts and stops generation
// - programmed period is cycles minus one
// - periods held as high and low bytes
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "pmftg_map.svh"
module pmftg_top
  import pmftg_pkg::*;
#(
  parameter int ADDR_W = 12,  // apb address width
  parameter int NRX    = 4,   // receive ports
  parameter int NTX    = 2,   // transmit ports
  parameter int NGPIO  = 8    // external trigger pins
)
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  pclk_en,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire pmftg_rx_s [NRX-1:0]   rx_status,
  input  wire pmftg_tx_s [NTX-1:0]   tx_status,
  input  wire logic [NRX-1:0]        bc_frame_tick,
  input  wire logic                  ref_tick,
  input  wire logic [NGPIO-1:0]      gpio_in,
  output logic                       pin7_out,
  output logic                       pin7_oe,
  output logic                       camera_trigger_pulse
);
  // ****************************************
  // register state
  // ****************************************
  logic [7:0]     pin_ctl_q,  pin_ctl_d;   // pin7_output_control
  logic [7:0]     trg_ctl_q,  trg_ctl_d;   // frame_trigger_control
  logic [7:0]     high1_q,    high1_d;     // high period 15:8
  logic [7:0]     high0_q,    high0_d;     // high period 7:0
  logic [7:0]     low1_q,     low1_d;      // low period 15:8
  logic [7:0]     low0_q,     low0_d;      // low period 7:0
  logic [NRX-1:0] mask_q,     mask_d;      // enabled receive ports
  logic           single_q,   single_d;    // one-cycle single request
  logic [31:0]    rdata_q,    rdata_d;     // read data
  logic           ready_q,    ready_d;     // access-phase answer
  logic           err_q,      err_d;       // unmapped address

  // ****************************************
  // pin and trigger state
  // ****************************************
  logic           pin_q,      pin_d;       // pin level
  logic           oe_q,       oe_d;        // pin driver enable
  logic           ext_q,      ext_d;       // sampled external trigger
  logic           trig_q,     trig_d;      // trigger seen by the pin
  logic           gen_level;               // generator level
  logic           gen_busy;                // generator running
  logic           gen_tick;                // selected timebase tick
  logic           gen_on;                  // internal mode selected
  logic [23:0]    high_len;                // high phase length
  logic [23:0]    low_len;                 // low phase length

  // ****************************************
  // helpers
  // ****************************************
  // register index of an address; upper bits are cut, so the decode checks them too
  function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
    idx_of = 8'(a[ADDR_W-1:2]);
  endfunction

  // and over the enabled ports of one status bit, true if none enabled
  function automatic logic and_en(input logic [NRX-1:0] v,
                                  input logic [NRX-1:0] m);
    and_en = &(v | ~m);
  endfunction

  // or over the enabled ports of one status bit
  function automatic logic or_en(input logic [NRX-1:0] v,
                                 input logic [NRX-1:0] m);
    or_en = |(v & m);
  endfunction

  // ****************************************
  // status bits gathered per port
  // ****************************************
  logic [NRX-1:0] lock_v;  // lock of each port
  logic [NRX-1:0] pass_v;  // pass of each port
  always_comb
  begin
    for (int i = 0; i < NRX; i++)
    begin
      lock_v[i] = rx_status[i].lock;
      pass_v[i] = rx_status[i].pass;
    end
  end

  // ****************************************
  // apb slave: one wait state, then answer
  // ****************************************
  logic access;  // access phase of a transfer
  logic commit;  // edge at which the transfer completes
  logic hit;     // address maps to a register
  assign access = psel & penable;
  assign commit = access & ready_q;

  always_comb
  begin
    logic [7:0] idx;
    idx       = idx_of(paddr);
    // the full word address must match, or high addresses would alias onto registers
    hit       = (paddr[1:0] == 2'b00) && ((paddr >> 2) == ADDR_W'(idx)) &&
                (idx == `PMFTG_IDX_PIN_CTL   || idx == `PMFTG_IDX_TRIG_CTL ||
                 idx == `PMFTG_IDX_HIGH_1    || idx == `PMFTG_IDX_HIGH_0   ||
                 idx == `PMFTG_IDX_LOW_1     || idx == `PMFTG_IDX_LOW_0    ||
                 idx == `PMFTG_IDX_PORT_MASK || idx == `PMFTG_IDX_STATUS);
    pin_ctl_d = pin_ctl_q;
    trg_ctl_d = trg_ctl_q;
    high1_d   = high1_q;
    high0_d   = high0_q;
    low1_d    = low1_q;
    low0_d    = low0_q;
    mask_d    = mask_q;
    single_d  = 1'b0;  // self-clearing request
    // answer comes one cycle into the access phase, then drops
    ready_d   = access & ~ready_q;
    err_d     = access & ~ready_q & ~hit;
    rdata_d   = rdata_q;
    if (access && !ready_q)
    begin
      // read data is prepared while pready is still low
      rdata_d = '0;
      unique case (idx)
        `PMFTG_IDX_PIN_CTL:   rdata_d[7:0] = pin_ctl_q;
        `PMFTG_IDX_TRIG_CTL:  rdata_d[7:0] = trg_ctl_q;  // single reads 0
        `PMFTG_IDX_HIGH_1:    rdata_d[7:0] = high1_q;
        `PMFTG_IDX_HIGH_0:    rdata_d[7:0] = high0_q;
        `PMFTG_IDX_LOW_1:     rdata_d[7:0] = low1_q;
        `PMFTG_IDX_LOW_0:     rdata_d[7:0] = low0_q;
        `PMFTG_IDX_PORT_MASK: rdata_d[NRX-1:0] = mask_q;
        `PMFTG_IDX_STATUS:    rdata_d[2:0] = {gen_busy, trig_q, pin_q};
        default:              rdata_d = '0;
      endcase
      if (!hit)
      begin
        rdata_d = '0;  // misaligned or unmapped reads zero
      end
    end
    if (commit && pwrite && hit && pstrb[0])
    begin
      // writes land only at the completing edge
      unique case (idx)
        `PMFTG_IDX_PIN_CTL:   pin_ctl_d = pwdata[7:0];
        `PMFTG_IDX_TRIG_CTL:
        begin
          trg_ctl_d = pwdata[7:0];
          trg_ctl_d[`PMFTG_TRG_SINGLE] = 1'b0;          // never stored
          single_d  = pwdata[`PMFTG_TRG_SINGLE];
        end
        `PMFTG_IDX_HIGH_1:    high1_d = pwdata[7:0];
        `PMFTG_IDX_HIGH_0:    high0_d = pwdata[7:0];
        `PMFTG_IDX_LOW_1:     low1_d  = pwdata[7:0];
        `PMFTG_IDX_LOW_0:     low0_d  = pwdata[7:0];
        `PMFTG_IDX_PORT_MASK: mask_d  = pwdata[NRX-1:0];
        default:              mask_d  = mask_q;         // status is read-only
      endcase
    end
  end

  // register group: bus-written registers and bus answer; status bits come from the pin group and the generator
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_ctl_q <= `PMFTG_RST_BYTE;  // driver off after reset
      trg_ctl_q <= `PMFTG_RST_BYTE;  // generation off after reset
      high1_q   <= `PMFTG_RST_BYTE;
      high0_q   <= `PMFTG_RST_BYTE;
      low1_q    <= `PMFTG_RST_BYTE;
      low0_q    <= `PMFTG_RST_BYTE;
      mask_q    <= `PMFTG_RST_MASK;
      single_q  <= 1'b0;
      rdata_q   <= '0;
      ready_q   <= 1'b0;
      err_q     <= 1'b0;
    end
    else if (pclk_en)
    begin
      pin_ctl_q <= pin_ctl_d;
      trg_ctl_q <= trg_ctl_d;
      high1_q   <= high1_d;
      high0_q   <= high0_d;
      low1_q    <= low1_d;
      low0_q    <= low0_d;
      mask_q    <= mask_d;
      single_q  <= single_d;
      rdata_q   <= rdata_d;
      ready_q   <= ready_d;
      err_q     <= err_d;
    end
  end

  assign prdata  = rdata_q;
  assign pready  = ready_q;
  assign pslverr = err_q;

  // ****************************************
  // trigger timebase and periods
  // ****************************************
  logic [3:0] mode;  // trigger_source_mode
  assign mode   = trg_ctl_q[`PMFTG_TRG_MODE];
  assign gen_on = ~mode[3];  // 1xxx means external
  // 00xx: back-channel frame clock of one port
  // 01xx: reference clock
  assign gen_tick = mode[2] ? ref_tick : bc_frame_tick[mode[1:0]];

  always_comb
  begin
    if (trg_ctl_q[`PMFTG_TRG_DUTY])
    begin
      // 50/50: one 24-bit period for both phases
      high_len = {high0_q, low1_q, low0_q};
      low_len  = {high0_q, low1_q, low0_q};
    end
    else
    begin
      // high/low: two separate 16-bit periods
      high_len = {8'h00, high1_q, high0_q};
      low_len  = {8'h00, low1_q, low0_q};
    end
  end

  // generator; in external mode it is held idle at the initial level
  pmftg_trig_gen #(
    .LEN_W (24)
  ) u_gen (
    .pclk       (pclk),
    .presetn    (presetn),
    .pclk_en    (pclk_en),
    .tick       (gen_tick),
    .cont_en    (trg_ctl_q[`PMFTG_TRG_ENABLE] & gen_on),
    .single_go  (single_q & gen_on),
    .init_level (trg_ctl_q[`PMFTG_TRG_INIT]),
    .high_len   (high_len),
    .low_len    (low_len),
    .trig_out   (gen_level),
    .busy       (gen_busy)
  );

  // ****************************************
  // pin output multiplexer
  // ****************************************
  always_comb
  begin
    logic [2:0] src;
    logic [2:0] sel;
    logic [1:0] p;
    src   = pin_ctl_q[`PMFTG_PIN_SRC];
    sel   = pin_ctl_q[`PMFTG_PIN_SEL];
    p     = src[1:0];
    // external pin sampled once; inputs are synchronous
    ext_d  = gpio_in[mode[2:0]];
    trig_d = gen_on ? gen_level : ext_q;
    oe_d   = pin_ctl_q[`PMFTG_PIN_EN];
    pin_d  = 1'b0;
    if (!src[2])
    begin
      // receive port source
      unique case (sel)
        3'h0, 3'h1, 3'h2, 3'h3: pin_d = rx_status[p].fwd[sel[1:0]];
        3'h4:                   pin_d = rx_status[p].lock;
        3'h5:                   pin_d = rx_status[p].pass;
        3'h6:                   pin_d = rx_status[p].fv;
        3'h7:                   pin_d = rx_status[p].lv;
      endcase
    end
    else if (src == `PMFTG_SRC_STATUS)
    begin
      // device status source
      unique case (sel)
        3'h0:    pin_d = pin_ctl_q[`PMFTG_PIN_VAL];
        3'h1:    pin_d = or_en(lock_v, mask_q);
        3'h2:    pin_d = and_en(lock_v, mask_q);
        3'h3:    pin_d = and_en(pass_v, mask_q);
        3'h4:    pin_d = trig_q;
        default: pin_d = 1'b0;  // reserved selects drive low
      endcase
    end
    else if (src != `PMFTG_SRC_RSVD)
    begin
      // transmit port source, port in bit 0
      unique case (sel)
        3'h0:    pin_d = and_en(pass_v, mask_q);
        3'h1:    pin_d = or_en(pass_v, mask_q);
        3'h2:    pin_d = tx_status[src[0]].fv;
        3'h3:    pin_d = tx_status[src[0]].lv;
        3'h4:    pin_d = tx_status[src[0]].synced;
        3'h5:    pin_d = tx_status[src[0]].irq;
        default: pin_d = 1'b0;  // reserved selects drive low
      endcase
    end
  end

  // register group: pin and trigger pipeline
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_q  <= 1'b0;
      oe_q   <= 1'b0;
      ext_q  <= 1'b0;
      trig_q <= 1'b0;
    end
    else if (pclk_en)
    begin
      pin_q  <= pin_d;
      oe_q   <= oe_d;
      ext_q  <= ext_d;
      trig_q <= trig_d;
    end
  end

  assign pin7_out             = pin_q;
  assign pin7_oe              = oe_q;
  assign camera_trigger_pulse = trig_q;
endmodule

// ---- pmftg_props.sv ----
`timescale 1ns/1ps
`include "pmftg_map.svh"
// ****************************************
// bus and pin checker
// ****************************************
module pmftg_props
#(
  parameter int ADDR_W = 12  // apb address width
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              pclk_en,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              pin7_oe,
  input wire logic              camera_trigger_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // one wait state: ready lands in the second access cycle
  a_ready_timing: assert property ((psel && !penable && pclk_en) ##1 (psel && penable && pclk_en)
    |=> pready) else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
  a_error_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000) else $error("upper bits");
  a_single_zero: assert property (
    pready && !pwrite && paddr == {`PMFTG_IDX_TRIG_CTL, 2'b00} |-> !prdata[`PMFTG_TRG_SINGLE])
    else $error("single bit read one");
  a_misalign_err: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned accepted");
  // outputs still quiet at the first edge after reset
  a_reset_quiet: assert property (
    !$past(presetn) |-> !pin7_oe && !camera_trigger_pulse)
    else $error("outputs active after reset");
endmodule
bind pmftg_top pmftg_props #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk), .presetn(presetn),
  .pclk_en(pclk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin7_oe(pin7_oe),
  .camera_trigger_pulse(camera_trigger_pulse));

// ---- pmftg_far_model.sv ----
`timescale 1ns/1ps
// ****************************************
// far side timebases
// ****************************************
module pmftg_far_model
(
  input wire logic pclk,
  input wire logic presetn,
  output logic [3:0] bc_frame_tick,
  output logic       ref_tick
);
  logic [3:0] cnt_q [0:4];  // free running dividers, port i every i+1 cycles
  // reference tick every 10 cycles: 25 MHz against a 250 MHz clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    for (int i = 0; i < 5; i++)
    begin
      if (!presetn)
        cnt_q[i] <= 4'h0;
      else
        cnt_q[i] <= (cnt_q[i] == ((i < 4) ? i : 9)) ? 4'h0 : cnt_q[i] + 4'h1;
    end
  end
  // frame clocks differ per port so a wrong port choice shows
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      bc_frame_tick[i] = (cnt_q[i] == 4'h0);
    ref_tick = (cnt_q[4] == 4'h0);
  end
endmodule

// ---- pmftg_top_bench.sv ----
`timescale 1ns/1ps
`include "pmftg_map.svh"
module pmftg_top_bench;
  import pmftg_pkg::*;
  logic pclk, presetn, pclk_en, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, bc_frame_tick;
  pmftg_rx_s [3:0] rx_status;  // receive port levels
  pmftg_tx_s [1:0] tx_status;  // transmit port levels
  logic ref_tick, pin7_out, pin7_oe, camera_trigger_pulse, err;
  logic [7:0]  gpio_in;
  int          errors, comparisons, per;
  logic [31:0] rxp [3] = '{32'h8C4AE1F7, 32'h73B51E08, 32'hFFFFFFFF};
  logic [7:0]  txp [3] = '{8'h96, 8'h69, 8'hFF};
  logic [7:0]  ridx [8] = '{8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h30, 8'h31};
  always #2 pclk = ~pclk;
  pmftg_top dut (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_status(rx_status),
    .tx_status(tx_status), .bc_frame_tick(bc_frame_tick), .ref_tick(ref_tick),
    .gpio_in(gpio_in), .pin7_out(pin7_out), .pin7_oe(pin7_oe),
    .camera_trigger_pulse(camera_trigger_pulse));
  pmftg_far_model far (.pclk(pclk), .presetn(presetn), .bc_frame_tick(bc_frame_tick),
    .ref_tick(ref_tick));
  // ****************************************
  // tasks
  // ****************************************
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: %s got %0h want %0h", $time, m, g, e);
    end
  endtask
  // one apb transfer; request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      errors++;
      $display("wrong value at %0t: no ready", $time);
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, {2'b00, i, 2'b00}, d);
  endtask
  task automatic rdchk(input logic [7:0] i, input logic [7:0] e);
    apb(1'b0, {2'b00, i, 2'b00}, 8'h00);
    chk(rd, {24'h000000, e}, "readback");
  endtask
  task automatic wait_at(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask
  // a wait loop that used up its bound ends the run as a mismatch
  task automatic bound(input int n);
    if (n >= 500)
    begin
      errors++;
      $display("wrong value at %0t: no trigger edge", $time);
      finish_test();
    end
  endtask
  // length of the next whole phase at level lvl; bounded waits
  task automatic measure(input logic lvl, input int e);
    int n;
    wait_at(1);
    for (n = 0; camera_trigger_pulse === lvl && n < 500; n++) wait_at(1);
    bound(n);
    for (n = 0; camera_trigger_pulse !== lvl && n < 500; n++) wait_at(1);
    bound(n);
    for (n = 0; camera_trigger_pulse === lvl && n < 500; n++) wait_at(1);
    bound(n);
    chk(n, e, "phase length");
  endtask
  // pin level expected from source, select and port levels, all ports enabled
  function automatic logic exp_pin(input logic [2:0] s, input logic [2:0] e,
                                   input logic [31:0] rx, input logic [7:0] tx);
    logic [7:0] r;
    logic [3:0] t, lk, ps;
    r = rx[s[1:0]*8 +: 8];
    t = tx[s[0]*4 +: 4];
    for (int i = 0; i < 4; i++)
    begin
      lk[i] = rx[i*8+3];
      ps[i] = rx[i*8+2];
    end
    if (s < 3'h4)
      return (e < 3'h4) ? r[4+e] : r[7-e];
    if (s == 3'h4)
      return (e == 3'h0) ? rx[0] : (e == 3'h1) ? |lk : (e == 3'h2) ? &lk : (e == 3'h3) ? &ps : 1'b0;
    if (s == 3'h5)
      return 1'b0;
    return (e == 3'h0) ? &ps : (e == 3'h1) ? |ps : (e < 3'h6) ? t[5-e] : 1'b0;
  endfunction
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, gpio_in} = '0;
    {pclk_en, pstrb, rx_status, tx_status, errors, comparisons} = {5'h1F, 40'h0, 64'h0};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ridx[i]) rdchk(ridx[i], (ridx[i] == 8'h30) ? 8'h0F : 8'h00);
    apb(1'b0, 12'h080, 8'h00);
    chk({rd[7:0], err}, 9'h001, "unmapped");
    apb(1'b0, 12'h05D, 8'h00);
    chk(err, 1'b1, "misaligned");
    apb(1'b0, 12'h45C, 8'h00);
    chk(err, 1'b1, "aliased index");
    for (int i = 8'h17; i < 8'h1D; i++)
    begin
      wr(i, 8'hF5 - i);
      rdchk(i, (i == 8'h18) ? 8'hF5 - i - 8'h08 : 8'hF5 - i);
    end
    wr(`PMFTG_IDX_TRIG_CTL, 8'h00);
    $display("test registers done");
    for (int p = 0; p < 3; p++)
    begin
      @(posedge pclk);
      rx_status <= rxp[p];
      tx_status <= txp[p];
      for (int s = 0; s < 8; s++)
        for (int e = 0; e < 8; e++)
        begin
          wr(`PMFTG_IDX_PIN_CTL, {e[2:0], s[2:0], rxp[p][0], 1'b1});
          wait_at(3);
          chk({pin7_oe, pin7_out}, {1'b1, exp_pin(s, e, rxp[p], txp[p])}, "mux");
        end
    end
    wr(`PMFTG_IDX_PIN_CTL, 8'h12);
    wait_at(3);
    chk(pin7_oe, 1'b0, "driver off");
    // only ports 2 and 3 are locked: the mask must change the and and the or
    @(posedge pclk);
    rx_status <= rxp[0];
    wr(`PMFTG_IDX_PORT_MASK, 8'h0C);
    wr(`PMFTG_IDX_PIN_CTL, 8'h51);
    wait_at(3);
    chk(pin7_out, 1'b1, "lock and over mask");
    wr(`PMFTG_IDX_PORT_MASK, 8'h03);
    wr(`PMFTG_IDX_PIN_CTL, 8'h31);
    wait_at(3);
    chk(pin7_out, 1'b0, "lock or over mask");
    rdchk(`PMFTG_IDX_PORT_MASK, 8'h03);
    $display("test pin mux done");
    wr(`PMFTG_IDX_HIGH_1, 8'h00);
    wr(`PMFTG_IDX_HIGH_0, 8'h01);
    wr(`PMFTG_IDX_LOW_1, 8'h00);
    wr(`PMFTG_IDX_LOW_0, 8'h00);
    for (int m = 0; m < 8; m++)
    begin
      per = (m < 4) ? m + 1 : 10;
      wr(`PMFTG_IDX_TRIG_CTL, {m[3:0], 4'h0});
      wr(`PMFTG_IDX_TRIG_CTL, {m[3:0], 4'h1});
      measure(1'b1, 2 * per);
      measure(1'b0, per);
    end
    wr(`PMFTG_IDX_HIGH_1, 8'h55);
    wr(`PMFTG_IDX_HIGH_0, 8'h00);
    wr(`PMFTG_IDX_LOW_0, 8'h03);
    wr(`PMFTG_IDX_TRIG_CTL, 8'h03);
    measure(1'b1, 4);
    measure(1'b0, 4);
    wr(`PMFTG_IDX_TRIG_CTL, 8'h00);
    wait_at(4);
    chk(camera_trigger_pulse, 1'b0, "stopped");
    wr(`PMFTG_IDX_TRIG_CTL, 8'h04);
    wait_at(4);
    chk(camera_trigger_pulse, 1'b1, "idle high");
    wr(`PMFTG_IDX_TRIG_CTL, 8'h0C);
    measure(1'b0, 4);
    for (int i = 0; i < 12; i++)
    begin
      wait_at(1);
      chk(camera_trigger_pulse, 1'b1, "one pulse only");
    end
    rdchk(`PMFTG_IDX_TRIG_CTL, 8'h04);
    $display("test generator done");
    for (int k = 0; k < 8; k++)
    begin
      wr(`PMFTG_IDX_TRIG_CTL, {1'b1, k[2:0], 4'h0});
      gpio_in <= 8'h01 << k;
      wait_at(4);
      chk(camera_trigger_pulse, 1'b1, "external high");
      @(posedge pclk);
      gpio_in <= ~(8'h01 << k);
      wait_at(4);
      chk(camera_trigger_pulse, 1'b0, "external low");
    end
    wr(`PMFTG_IDX_PIN_CTL, 8'h91);
    gpio_in <= 8'h80;
    wait_at(6);
    chk(pin7_out, 1'b1, "trigger on pin");
    $display("test external done");
    finish_test();
  end
endmodule
